// ---- hdl/uhmds_top.v ----
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "uhmds_consts.vh"
module uhmds_top (
	// clock and master reset
	input  wire       MCLK,
	input  wire       RST_N,
	// register port
	input  wire       CS,
	input  wire [2:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WRITE_STROBE,
	input  wire       READ_STROBE,
	input  wire       READ_STROBE_N,
	output reg  [7:0] RDATA,
	// serial line
	input  wire       RCLK,
	input  wire       SERIAL_IN,
	output reg        SERIAL_OUT,
	// modem lines
	input  wire       CALL_ALERT_N,
	output reg        REQUEST_TO_SEND_N,
	// dma and interrupt
	output reg        RX_DMA_REQUEST_N,
	output reg        TX_DMA_REQUEST_N,
	output reg        IRQ_OUT
);
	// ****************************************
	// functions
	// ****************************************
	function [4:0] fifo_cap;
		input en;
		begin
			fifo_cap = en ? `UHMDS_DEPTH : 5'h01;
		end
	endfunction

	function [3:0] ptr_inc;
		input [3:0] p;
		begin
			ptr_inc = p + 4'h1;
		end
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	wire [2:0] pins_s;
	wire       rclk_s;
	wire       sin_s;
	wire       alert_s;

	uhmds_sync #(.W(3), .RV(1'b1)) u_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.d     ({RCLK, SERIAL_IN, CALL_ALERT_N}),
		.q     (pins_s)
	);
	assign rclk_s = pins_s[2];
	assign sin_s  = pins_s[1];
	assign alert_s = pins_s[0];

	reg  rclk_d;
	reg  alert_d;
	wire tick;
	wire alert_rise;

	assign tick       = rclk_s & ~rclk_d;
	assign alert_rise = alert_s & ~alert_d;

	// ****************************************
	// control registers and decode
	// ****************************************
	reg  [7:0] mctl;
	reg  [7:0] fctl;
	reg  [3:0] mask;
	reg  [3:0] status;
	reg        edge_flag;
	reg        overrun;
	wire       rd;
	wire       wr;
	wire       loop;
	wire       fifo_en;
	wire       mode1;
	reg  [4:0] trig;

	assign rd      = CS & (READ_STROBE | ~READ_STROBE_N);
	assign wr      = CS & WRITE_STROBE;
	assign loop    = mctl[`UHMDS_MCTL_LOOP];
	assign fifo_en = fctl[`UHMDS_FCTL_EN];
	assign mode1   = fifo_en & fctl[`UHMDS_FCTL_DMA];

	always @* begin
		case (fctl[`UHMDS_FCTL_TRH:`UHMDS_FCTL_TRL])
		2'h0:    trig = `UHMDS_TRIG0;
		2'h1:    trig = `UHMDS_TRIG1;
		2'h2:    trig = `UHMDS_TRIG2;
		default: trig = `UHMDS_TRIG3;
		endcase
	end

	wire wr_fctl;
	wire rx_clr;
	wire tx_clr;

	// toggling fifo enable flushes both queues
	assign wr_fctl = wr & (ADDR == `UHMDS_A_FCTL);
	assign rx_clr  = wr_fctl & (WDATA[`UHMDS_FCTL_RXCL] | (WDATA[`UHMDS_FCTL_EN] != fifo_en));
	assign tx_clr  = wr_fctl & (WDATA[`UHMDS_FCTL_TXCL] | (WDATA[`UHMDS_FCTL_EN] != fifo_en));

	// ****************************************
	// receiver and receive queue
	// ****************************************
	reg        tx_line;
	wire [7:0] rx_data;
	wire       rx_valid;

	uhmds_rx u_rx (
		.clk   (MCLK),
		.rst_n (RST_N),
		.tick  (tick),
		.rxd   (loop ? tx_line : sin_s),
		.data  (rx_data),
		.valid (rx_valid)
	);

	reg  [7:0] rx_mem [0:15];
	reg  [3:0] rx_wp;
	reg  [3:0] rx_rp;
	reg  [4:0] rx_cnt;
	wire       rx_pop;
	wire       rx_push;

	assign rx_pop  = rd & (ADDR == `UHMDS_A_DATA) & (rx_cnt != 5'h00);
	// holding only one character while FIFOs are off
	assign rx_push = rx_valid & (rx_cnt < fifo_cap(fifo_en));

	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_wp  <= 4'h0;
			rx_rp  <= 4'h0;
			rx_cnt <= 5'h00;
		end else if (rx_clr) begin
			rx_wp  <= 4'h0;
			rx_rp  <= 4'h0;
			rx_cnt <= 5'h00;
		end else begin
			if (rx_push)
				rx_wp <= ptr_inc(rx_wp);
			if (rx_pop)
				rx_rp <= ptr_inc(rx_rp);
			rx_cnt <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
		end
	end

	always @(posedge MCLK) begin
		if (rx_push)
			rx_mem[rx_wp] <= rx_data;
	end

	// ****************************************
	// receive time-out
	// ****************************************
	reg [9:0] tout_cnt;
	reg       tout;

	// idle four character times with data held
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tout_cnt <= 10'h000;
			tout     <= 1'b0;
		end else if (rx_push | rx_pop | rx_clr | (rx_cnt == 5'h00)) begin
			tout_cnt <= 10'h000;
			tout     <= 1'b0;
		end else if (tick) begin
			if (tout_cnt == `UHMDS_TOUT)
				tout <= 1'b1;
			else
				tout_cnt <= tout_cnt + 10'h001;
		end
	end

	// ****************************************
	// transmit queue and serialiser
	// ****************************************
	reg  [7:0] tx_mem [0:15];
	reg  [3:0] tx_wp;
	reg  [3:0] tx_rp;
	reg  [4:0] tx_cnt;
	reg  [9:0] tx_sh;
	reg  [3:0] tx_bits;
	reg  [3:0] tx_tc;
	wire       tx_push;
	wire       tx_load;
	wire       tx_busy;

	// writes to a full queue are dropped
	assign tx_push = wr & (ADDR == `UHMDS_A_DATA) & (tx_cnt < fifo_cap(fifo_en));
	assign tx_busy = tx_bits != 4'h0;
	assign tx_load = ~tx_busy & (tx_cnt != 5'h00);

	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_wp  <= 4'h0;
			tx_rp  <= 4'h0;
			tx_cnt <= 5'h00;
		end else if (tx_clr) begin
			tx_wp  <= 4'h0;
			tx_rp  <= 4'h0;
			tx_cnt <= 5'h00;
		end else begin
			if (tx_push)
				tx_wp <= ptr_inc(tx_wp);
			if (tx_load)
				tx_rp <= ptr_inc(tx_rp);
			tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_load};
		end
	end

	always @(posedge MCLK) begin
		if (tx_push)
			tx_mem[tx_wp] <= WDATA;
	end

	// shares the receive tick, no baud generator here
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_sh   <= 10'h3FF;
			tx_bits <= 4'h0;
			tx_tc   <= 4'h0;
			tx_line <= 1'b1;
		end else if (tx_load) begin
			tx_sh   <= {1'b1, tx_mem[tx_rp], 1'b0};
			tx_bits <= `UHMDS_TX_BITS;
			tx_tc   <= 4'h0;
		end else if (tx_busy & tick) begin
			tx_line <= tx_sh[0];
			tx_tc   <= tx_tc + 4'h1;
			if (tx_tc == `UHMDS_OVS_LAST) begin
				tx_sh   <= {1'b1, tx_sh[9:1]};
				tx_bits <= tx_bits - 4'h1;
			end
		end else if (~tx_busy) begin
			tx_line <= 1'b1;
		end
	end

	// ****************************************
	// events and interrupt
	// ****************************************
	reg        rx_trig_d;
	reg        tx_empty_d;
	wire       rx_trig;
	wire       tx_empty;
	wire [3:0] ev;
	wire [3:0] st_clr;
	wire [3:0] next_status;
	reg        tout_d;

	assign rx_trig  = rx_cnt >= trig;
	assign tx_empty = (tx_cnt == 5'h00) & ~tx_busy;
	assign ev = {tout & ~tout_d, alert_rise, tx_empty & ~tx_empty_d, rx_trig & ~rx_trig_d};
	assign st_clr = (wr & (ADDR == `UHMDS_A_STAT)) ? WDATA[3:0] : 4'h0;
	assign next_status = (status & ~st_clr) | ev;

	// ****************************************
	// register file
	// ****************************************
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			mctl       <= `UHMDS_RV_MCTL;
			fctl       <= `UHMDS_RV_FCTL;
			mask       <= `UHMDS_RV_MASK;
			status     <= 4'h0;
			edge_flag  <= 1'b0;
			overrun    <= 1'b0;
			rclk_d     <= 1'b1;
			alert_d    <= 1'b1;
			rx_trig_d  <= 1'b0;
			tx_empty_d <= 1'b1;
			tout_d     <= 1'b0;
			RDATA      <= 8'h00;
			IRQ_OUT    <= 1'b0;
		end else begin
			rclk_d     <= rclk_s;
			alert_d    <= alert_s;
			rx_trig_d  <= rx_trig;
			tx_empty_d <= tx_empty;
			tout_d     <= tout;
			status     <= next_status;
			IRQ_OUT    <= |(next_status & mask);
			if (wr & (ADDR == `UHMDS_A_MCTL))
				mctl <= WDATA;
			if (wr_fctl)
				fctl <= WDATA;
			if (wr & (ADDR == `UHMDS_A_MASK))
				mask <= WDATA[3:0];
			if (alert_rise)
				edge_flag <= 1'b1;
			else if (rd & (ADDR == `UHMDS_A_MSR))
				edge_flag <= 1'b0;
			if (rx_valid & ~rx_push)
				overrun <= 1'b1;
			else if (rd & (ADDR == `UHMDS_A_LSR))
				overrun <= 1'b0;
			RDATA <= 8'h00;
			if (rd) begin
				case (ADDR)
				`UHMDS_A_DATA: RDATA <= (rx_cnt != 5'h00) ? rx_mem[rx_rp] : 8'h00;
				`UHMDS_A_MASK: RDATA <= {4'h0, mask};
				`UHMDS_A_FCTL: RDATA <= fctl;
				`UHMDS_A_MCTL: RDATA <= mctl;
				`UHMDS_A_LSR: begin
					RDATA[`UHMDS_LSR_DR]   <= rx_cnt != 5'h00;
					RDATA[`UHMDS_LSR_OE]   <= overrun;
					RDATA[`UHMDS_LSR_THRE] <= tx_cnt == 5'h00;
					RDATA[`UHMDS_LSR_TEMT] <= tx_empty;
				end
				`UHMDS_A_MSR: begin
					RDATA[`UHMDS_MSR_LVL]  <= alert_s;
					RDATA[`UHMDS_MSR_EDGE] <= edge_flag;
				end
				`UHMDS_A_STAT: RDATA <= {4'h0, status};
				default:       RDATA <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************
	// modem and dma outputs
	// ****************************************
	reg  rx_dma_act;
	wire rts_hold;

	assign rts_hold = mctl[`UHMDS_MCTL_AUTO] & rx_trig;

	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			REQUEST_TO_SEND_N <= 1'b1;
			SERIAL_OUT        <= 1'b1;
			rx_dma_act        <= 1'b0;
			RX_DMA_REQUEST_N  <= 1'b1;
			TX_DMA_REQUEST_N  <= 1'b0;
		end else begin
			REQUEST_TO_SEND_N <= ~(mctl[`UHMDS_MCTL_RTS] & ~loop & ~rts_hold);
			// loopback keeps the line marking
			SERIAL_OUT <= tx_line | loop;
			if (rx_cnt == 5'h00)
				rx_dma_act <= 1'b0;
			else if (rx_trig | tout)
				rx_dma_act <= 1'b1;
			RX_DMA_REQUEST_N <= mode1 ? ~rx_dma_act : (rx_cnt == 5'h00);
			TX_DMA_REQUEST_N <= mode1 ? ~(tx_cnt < fifo_cap(fifo_en)) : (tx_cnt != 5'h00);
		end
	end
endmodule
`default_nettype wire

// ---- include/uhmds_consts.vh ----
`ifndef UHMDS_CONSTS_VH
`define UHMDS_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define UHMDS_A_DATA   3'h0
`define UHMDS_A_MASK   3'h1
`define UHMDS_A_FCTL   3'h2
`define UHMDS_A_MCTL   3'h4
`define UHMDS_A_LSR    3'h5
`define UHMDS_A_MSR    3'h6
`define UHMDS_A_STAT   3'h7
// ****************************************
// field positions
// ****************************************
`define UHMDS_MCTL_RTS  1
`define UHMDS_MCTL_LOOP 4
`define UHMDS_MCTL_AUTO 5
`define UHMDS_FCTL_EN   0
`define UHMDS_FCTL_RXCL 1
`define UHMDS_FCTL_TXCL 2
`define UHMDS_FCTL_DMA  3
`define UHMDS_FCTL_TRH  7
`define UHMDS_FCTL_TRL  6
`define UHMDS_MSR_EDGE 2
`define UHMDS_MSR_LVL  6
`define UHMDS_LSR_DR   0
`define UHMDS_LSR_OE   1
`define UHMDS_LSR_THRE 5
`define UHMDS_LSR_TEMT 6
`define UHMDS_ST_RX    0
`define UHMDS_ST_TX    1
`define UHMDS_ST_MDM   2
`define UHMDS_ST_TOUT  3
// ****************************************
// reset values and counts
// ****************************************
`define UHMDS_RV_MCTL  8'h00
`define UHMDS_RV_FCTL  8'h00
`define UHMDS_RV_MASK  4'h0
`define UHMDS_TRIG0    5'h01
`define UHMDS_TRIG1    5'h04
`define UHMDS_TRIG2    5'h08
`define UHMDS_TRIG3    5'h0E
`define UHMDS_DEPTH    5'h10
`define UHMDS_OVS_LAST 4'hF
`define UHMDS_OVS_MID  4'h7
`define UHMDS_TX_BITS  4'hA
`define UHMDS_TOUT     10'h280
`endif

// ---- hdl/uhmds_sync.v ----
`timescale 1ns/10ps
`default_nettype none
module uhmds_sync #(
	parameter W  = 1,
	parameter RV = 1'b0
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst_n,
	// levels
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta;

	// first stage feeds only the second
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= {W{RV}};
			q    <= {W{RV}};
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/uhmds_rx.v ----
`timescale 1ns/10ps
`default_nettype none
`include "uhmds_consts.vh"
module uhmds_rx (
	// clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// line side
	input  wire       tick,
	input  wire       rxd,
	// character out
	output reg  [7:0] data,
	output reg        valid
);
	localparam S_IDLE  = 2'h0;
	localparam S_START = 2'h1;
	localparam S_DATA  = 2'h2;
	localparam S_STOP  = 2'h3;

	reg [1:0] state;
	reg [3:0] cnt;
	reg [2:0] nbit;
	reg [7:0] sh;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			cnt   <= 4'h0;
			nbit  <= 3'h0;
			sh    <= 8'h00;
			data  <= 8'h00;
			valid <= 1'b0;
		end else begin
			valid <= 1'b0;
			if (tick) begin
				case (state)
				S_IDLE: begin
					cnt <= 4'h0;
					if (!rxd)
						state <= S_START;
				end
				S_START: begin
					// false start bits fall back to idle
					if (cnt == `UHMDS_OVS_MID) begin
						cnt   <= 4'h0;
						nbit  <= 3'h0;
						state <= rxd ? S_IDLE : S_DATA;
					end else
						cnt <= cnt + 4'h1;
				end
				S_DATA: begin
					cnt <= cnt + 4'h1;
					if (cnt == `UHMDS_OVS_LAST) begin
						sh   <= {rxd, sh[7:1]};
						nbit <= nbit + 3'h1;
						if (nbit == 3'h7)
							state <= S_STOP;
					end
				end
				S_STOP: begin
					cnt <= cnt + 4'h1;
					if (cnt == `UHMDS_OVS_LAST) begin
						state <= S_IDLE;
						// framing errors are dropped silently
						if (rxd) begin
							data  <= sh;
							valid <= 1'b1;
						end
					end
				end
				default: state <= S_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/uhmds_line_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module uhmds_line_model (
	// line side toward the block
	output var logic rclk,
	output var logic serial_in,
	output var logic call_alert_n
);
	// ****************************************
	// modem and serial line
	// ****************************************
	// sixteen ticks per bit; clock stands still between frames
	task automatic tick16;
		repeat (16) begin
			#16 rclk = 1'b1;
			#16 rclk = 1'b0;
		end
	endtask
	// start, eight bits lsb first, stop
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		integer     k;
		fr = {1'b1, b, 1'b0};
		for (k = 0; k < 10; k++) begin
			serial_in = fr[k];
			tick16;
		end
		tick16;
	endtask
	task automatic alert(input logic lvl);
		call_alert_n = lvl;
	endtask
	// idle line is marking, clock parked low
	initial begin
		rclk = 1'b0;
		serial_in = 1'b1;
		call_alert_n = 1'b1;
	end
endmodule
`default_nettype wire

// ---- verification/uhmds_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "uhmds_consts.vh"
module uhmds_chk (
	// clock and reset
	input wire logic       MCLK,
	input wire logic       RST_N,
	// register port
	input wire logic       CS,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WRITE_STROBE,
	input wire logic       READ_STROBE,
	input wire logic       READ_STROBE_N,
	input wire logic [7:0] RDATA,
	// pins
	input wire logic       CALL_ALERT_N,
	input wire logic       SERIAL_OUT,
	input wire logic       REQUEST_TO_SEND_N,
	input wire logic       RX_DMA_REQUEST_N,
	input wire logic       TX_DMA_REQUEST_N,
	input wire logic       IRQ_OUT
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	logic       rd;
	logic       wr;
	logic       rx_cause;
	logic       tx_cause;
	logic [3:0] msk;
	assign rd = CS && (READ_STROBE || !READ_STROBE_N);
	assign wr = CS && WRITE_STROBE;
	// a flush through the fifo control write also moves the dma pins
	assign rx_cause = (rd && ADDR == `UHMDS_A_DATA) || (wr && ADDR == `UHMDS_A_FCTL);
	assign tx_cause = wr && (ADDR == `UHMDS_A_DATA || ADDR == `UHMDS_A_FCTL);
	// mask shadow, only seen through writes
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			msk <= 4'h0;
		else if (wr && ADDR == `UHMDS_A_MASK)
			msk <= WDATA[3:0];
	end
	rdata_when_idle_a: assert property (!rd |=> RDATA == 8'h00)
		else $error("read data without a read");
	unmapped_read_a: assert property (rd && ADDR == 3'h3 |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	reset_levels_a: assert property ($rose(RST_N) |-> SERIAL_OUT && REQUEST_TO_SEND_N
		&& RX_DMA_REQUEST_N && !TX_DMA_REQUEST_N && !IRQ_OUT)
		else $error("pin levels wrong after reset");
	rts_drive_a: assert property (wr && ADDR == `UHMDS_A_MCTL && WDATA[1] && !WDATA[4] && !WDATA[5]
		|-> ##2 !REQUEST_TO_SEND_N)
		else $error("rts not driven low");
	rts_release_a: assert property (wr && ADDR == `UHMDS_A_MCTL && (WDATA[4] || !WDATA[1])
		|-> ##2 REQUEST_TO_SEND_N)
		else $error("rts not released");
	loop_idle_a: assert property (wr && ADDR == `UHMDS_A_MCTL && WDATA[4] |-> ##2 SERIAL_OUT[*2])
		else $error("serial out not marking in loopback");
	alert_irq_a: assert property ($rose(CALL_ALERT_N) && msk[2] |-> ##[2:7] IRQ_OUT)
		else $error("no irq after alert rise");
	mask_off_a: assert property (wr && ADDR == `UHMDS_A_MASK && WDATA[3:0] == 4'h0 |-> ##3 !IRQ_OUT)
		else $error("irq still high with mask clear");
	rx_release_a: assert property ($rose(RX_DMA_REQUEST_N)
		|-> $past(rx_cause, 1) || $past(rx_cause, 2) || $past(rx_cause, 3))
		else $error("rx request released without a read");
	tx_release_a: assert property ($rose(TX_DMA_REQUEST_N)
		|-> $past(tx_cause, 1) || $past(tx_cause, 2) || $past(tx_cause, 3))
		else $error("tx request released without a write");
endmodule
bind uhmds_top uhmds_chk i_chk (.MCLK(MCLK), .RST_N(RST_N), .CS(CS), .ADDR(ADDR), .WDATA(WDATA),
	.WRITE_STROBE(WRITE_STROBE), .READ_STROBE(READ_STROBE), .READ_STROBE_N(READ_STROBE_N),
	.RDATA(RDATA), .CALL_ALERT_N(CALL_ALERT_N), .SERIAL_OUT(SERIAL_OUT),
	.REQUEST_TO_SEND_N(REQUEST_TO_SEND_N), .RX_DMA_REQUEST_N(RX_DMA_REQUEST_N),
	.TX_DMA_REQUEST_N(TX_DMA_REQUEST_N), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "uhmds_consts.vh"
module tb;
	logic       MCLK;
	logic       RST_N;
	logic       CS;
	logic [2:0] ADDR;
	logic [7:0] WDATA;
	logic       WRITE_STROBE;
	logic       READ_STROBE;
	logic       READ_STROBE_N;
	wire  [7:0] RDATA;
	wire        RCLK;
	wire        SERIAL_IN;
	wire        SERIAL_OUT;
	wire        CALL_ALERT_N;
	wire        REQUEST_TO_SEND_N;
	wire        RX_DMA_REQUEST_N;
	wire        TX_DMA_REQUEST_N;
	wire        IRQ_OUT;
	integer     bad_count;
	integer     samples_checked;
	integer     i;
	logic [7:0] v;
	logic [7:0] mctl_tab [3] = '{8'h02, 8'h12, 8'h00};
	logic [2:0] rts_tab = 3'b110;
	uhmds_top i_dut (.MCLK(MCLK), .RST_N(RST_N), .CS(CS), .ADDR(ADDR), .WDATA(WDATA),
		.WRITE_STROBE(WRITE_STROBE), .READ_STROBE(READ_STROBE), .READ_STROBE_N(READ_STROBE_N),
		.RDATA(RDATA), .RCLK(RCLK), .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
		.CALL_ALERT_N(CALL_ALERT_N), .REQUEST_TO_SEND_N(REQUEST_TO_SEND_N),
		.RX_DMA_REQUEST_N(RX_DMA_REQUEST_N), .TX_DMA_REQUEST_N(TX_DMA_REQUEST_N), .IRQ_OUT(IRQ_OUT));
	uhmds_line_model i_line (.rclk(RCLK), .serial_in(SERIAL_IN), .call_alert_n(CALL_ALERT_N));
	// ****************************************
	// bus tasks and checks
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic pin(input logic s, input logic e);
		chk({7'h00, s}, {7'h00, e});
	endtask
	task automatic idle(input integer n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge MCLK);
		CS <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		WRITE_STROBE <= 1'b1;
		@(posedge MCLK);
		CS <= 1'b0;
		WRITE_STROBE <= 1'b0;
	endtask
	// one strobe per read, the other held inactive
	task automatic rd(input logic [2:0] a, input logic low, output logic [7:0] d);
		@(posedge MCLK);
		CS <= 1'b1;
		ADDR <= a;
		READ_STROBE <= !low;
		READ_STROBE_N <= !low;
		@(posedge MCLK);
		CS <= 1'b0;
		READ_STROBE <= 1'b0;
		READ_STROBE_N <= 1'b1;
		#1;
		d = RDATA;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		MCLK = 1'b0;
		forever #4 MCLK = ~MCLK;
	end
	// six frames of about 700 cycles and a 2560 cycle time-out wait; 25000 cycles is ample
	initial begin
		#200000;
		bad_count = bad_count + 1;
		$display("ERROR at %0t: run hung", $time);
		give_verdict;
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		bad_count = 0;
		samples_checked = 0;
		RST_N = 1'b0;
		CS = 1'b0;
		ADDR = 3'h0;
		WDATA = 8'h00;
		WRITE_STROBE = 1'b0;
		READ_STROBE = 1'b0;
		READ_STROBE_N = 1'b1;
		repeat (12) @(posedge MCLK);
		RST_N <= 1'b1;
		idle(1);
		pin(SERIAL_OUT, 1'b1);
		pin(REQUEST_TO_SEND_N, 1'b1);
		pin(RX_DMA_REQUEST_N, 1'b1);
		pin(TX_DMA_REQUEST_N, 1'b0);
		pin(IRQ_OUT, 1'b0);
		rd(`UHMDS_A_FCTL, 1'b0, v);
		chk(v, `UHMDS_RV_FCTL);
		wr(3'h3, 8'hFF);
		rd(3'h3, 1'b0, v);
		chk(v, 8'h00);
		for (i = 0; i < 3; i++) begin
			wr(`UHMDS_A_MCTL, mctl_tab[i]);
			idle(2);
			pin(REQUEST_TO_SEND_N, rts_tab[i]);
		end
		$display("test reset and rts done");
		wr(`UHMDS_A_MASK, 8'h04);
		i_line.alert(1'b0);
		idle(8);
		rd(`UHMDS_A_MSR, 1'b0, v);
		chk(v & 8'h44, 8'h00);
		i_line.alert(1'b1);
		idle(8);
		pin(IRQ_OUT, 1'b1);
		rd(`UHMDS_A_MSR, 1'b1, v);
		chk(v & 8'h44, 8'h44);
		rd(`UHMDS_A_MSR, 1'b0, v);
		chk(v & 8'h44, 8'h40);
		wr(`UHMDS_A_MASK, 8'h00);
		idle(3);
		pin(IRQ_OUT, 1'b0);
		wr(`UHMDS_A_MASK, 8'h04);
		idle(3);
		pin(IRQ_OUT, 1'b1);
		wr(`UHMDS_A_STAT, 8'h04);
		idle(3);
		pin(IRQ_OUT, 1'b0);
		$display("test alert done");
		i_line.send_byte(8'hA5);
		idle(4);
		pin(RX_DMA_REQUEST_N, 1'b0);
		rd(`UHMDS_A_LSR, 1'b0, v);
		chk(v, 8'h61);
		rd(`UHMDS_A_DATA, 1'b0, v);
		chk(v, 8'hA5);
		idle(3);
		pin(RX_DMA_REQUEST_N, 1'b1);
		// trigger level four, dma mode one, auto rts
		wr(`UHMDS_A_FCTL, 8'h49);
		wr(`UHMDS_A_MCTL, 8'h22);
		for (i = 0; i < 4; i++) begin
			i_line.send_byte(8'h30 + i[7:0]);
			idle(4);
			pin(RX_DMA_REQUEST_N, i < 3);
			pin(REQUEST_TO_SEND_N, i == 3);
		end
		for (i = 0; i < 4; i++) begin
			pin(RX_DMA_REQUEST_N, 1'b0);
			rd(`UHMDS_A_DATA, 1'b0, v);
			chk(v, 8'h30 + i[7:0]);
		end
		idle(3);
		pin(RX_DMA_REQUEST_N, 1'b1);
		pin(REQUEST_TO_SEND_N, 1'b0);
		$display("test receive done");
		// below trigger, so only the time-out may raise the request
		i_line.send_byte(8'h3C);
		idle(4);
		pin(RX_DMA_REQUEST_N, 1'b1);
		repeat (40) i_line.tick16;
		idle(4);
		pin(RX_DMA_REQUEST_N, 1'b0);
		rd(`UHMDS_A_STAT, 1'b0, v);
		chk(v & 8'h08, 8'h08);
		rd(`UHMDS_A_DATA, 1'b0, v);
		chk(v, 8'h3C);
		idle(3);
		pin(RX_DMA_REQUEST_N, 1'b1);
		$display("test time-out done");
		wr(`UHMDS_A_FCTL, 8'h09);
		idle(2);
		pin(TX_DMA_REQUEST_N, 1'b0);
		for (i = 0; i < 17; i++) begin
			if (i == 15)
				pin(TX_DMA_REQUEST_N, 1'b0);
			wr(`UHMDS_A_DATA, i[7:0]);
		end
		idle(2);
		pin(TX_DMA_REQUEST_N, 1'b1);
		wr(`UHMDS_A_FCTL, 8'h05);
		idle(2);
		pin(TX_DMA_REQUEST_N, 1'b0);
		wr(`UHMDS_A_DATA, 8'h5A);
		wr(`UHMDS_A_DATA, 8'hC3);
		idle(2);
		pin(TX_DMA_REQUEST_N, 1'b1);
		$display("test transmit done");
		give_verdict;
	end
endmodule
`default_nettype wire
